// ==== verilog/dmrm_pkg.sv ====
package dmrm_pkg;
  // Register numbers.
  localparam logic [5:0] DMRM_DEVICE_STATUS_INFO = 6'h00;
  localparam logic [5:0] DMRM_STROBE_TIMER_RUNTIME = 6'h17;
  localparam logic [5:0] DMRM_ROW_HAMMER_CONTROL = 6'h18;
  localparam logic [5:0] DMRM_PER_BANK_STATUS = 6'h19;
  localparam logic [5:0] DMRM_TEST_RESERVED_LOW = 6'h1e;
  localparam logic [5:0] DMRM_CALIB_PATTERN_FIRST = 6'h20;
  localparam logic [5:0] DMRM_TEST_RESERVED_HIGH = 6'h27;
  localparam logic [5:0] DMRM_CALIB_PATTERN_SECOND = 6'h28;
  localparam logic [5:0] DMRM_SINGLE_ENDED_SELECT = 6'h33;
  // Field positions.
  localparam int DMRM_REFRESH_MODE_BIT = 0;
  localparam int DMRM_SELFTEST_LSB = 3;
  localparam int DMRM_CA_TERM_BIT = 7;
  // Bits of the single-ended select register that are implemented.
  localparam logic [7:0] DMRM_SINGLE_ENDED_MASK = 8'h0e;
  // Self-test codes.
  localparam logic [1:0] DMRM_SELFTEST_INVALID = 2'h0;
  localparam logic [1:0] DMRM_SELFTEST_DEFAULT = 2'h1;
  localparam logic [1:0] DMRM_SELFTEST_OPEN = 2'h2;
  localparam logic [1:0] DMRM_SELFTEST_RESISTOR = 2'h3;
  // Reset values.
  localparam logic [7:0] DMRM_CALIB_FIRST_RESET = 8'h5a;
  localparam logic [7:0] DMRM_CALIB_SECOND_RESET = 8'h3c;
  localparam logic [7:0] DMRM_ZERO_RESET = 8'h00;
  // Latch time and derived cycle count at 10 MHz.
  localparam int DMRM_CLK_PERIOD_NS = 100;
  localparam int DMRM_LATCH_TIME_NS = 30;
  localparam int DMRM_LATCH_CYCLES = (DMRM_LATCH_TIME_NS + DMRM_CLK_PERIOD_NS - 1)
                                     / DMRM_CLK_PERIOD_NS;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] data;
  } dmrm_cmd_s;

  typedef struct packed {
    logic valid;
    logic strobe;
    logic [7:0] data;
  } dmrm_rsp_s;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_STARTED,
    CAL_LATCHING,
    CAL_DONE
  } dmrm_cal_e;
endpackage : dmrm_pkg

// ==== verilog/dmrm_regmem.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmrm_regmem #(
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Write port.
  input wire logic i_we,
  input wire logic [1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port.
  input wire logic [1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= dmrm_pkg::DMRM_ZERO_RESET;
      end
      mem[1] <= dmrm_pkg::DMRM_CALIB_FIRST_RESET;
      mem[2] <= dmrm_pkg::DMRM_CALIB_SECOND_RESET;
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rdata <= dmrm_pkg::DMRM_ZERO_RESET;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : dmrm_regmem
`default_nettype wire

// ==== verilog/dmrm_mode_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmrm_mode_regs
  import dmrm_pkg::*;
#(
  parameter int LATCH_CYCLES = dmrm_pkg::DMRM_LATCH_CYCLES,
  parameter int BANKS = 8
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Mode register commands.
  input wire dmrm_pkg::dmrm_cmd_s i_cmd,
  output dmrm_pkg::dmrm_rsp_s o_rsp,
  // Calibration commands and pin sense.
  input wire logic i_cal_start,
  input wire logic i_cal_latch,
  input wire logic [1:0] i_pin_sense,
  // Device state inputs.
  input wire logic i_refresh_modified_only,
  input wire logic i_ca_term_state,
  input wire logic [BANKS-1:0] i_bank_status,
  // Configuration outputs.
  output logic [7:0] o_strobe_timer_runtime,
  output logic [7:0] o_row_hammer_control,
  output logic [7:0] o_single_ended_select,
  output logic o_use_factory_trim,
  output logic o_cal_accepted
);
  import dmrm_pkg::*;

  dmrm_cal_e cal_state;
  logic [7:0] latch_cnt;
  logic [1:0] selftest;
  logic pend_rd;
  logic pend_strobe;
  logic [7:0] pend_data;
  logic pend_from_mem;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [1:0] mem_waddr;
  logic [1:0] mem_raddr;
  logic fault;
  logic start_ok;
  logic latch_ok;

  function automatic logic is_test_addr(input logic [5:0] a);
    return (a == DMRM_TEST_RESERVED_LOW) || (a == DMRM_TEST_RESERVED_HIGH);
  endfunction : is_test_addr

  function automatic logic [1:0] mem_slot(input logic [5:0] a);
    case (a)
      DMRM_STROBE_TIMER_RUNTIME: mem_slot = 2'h0;
      DMRM_CALIB_PATTERN_FIRST: mem_slot = 2'h1;
      DMRM_CALIB_PATTERN_SECOND: mem_slot = 2'h2;
      default: mem_slot = 2'h3;
    endcase
  endfunction : mem_slot

  assign fault = (selftest == DMRM_SELFTEST_DEFAULT) || (selftest == DMRM_SELFTEST_OPEN);
  // Acceptance mirrors the sequencer, so a stray latch with no start is not reported.
  assign start_ok = i_cal_start && !fault && ((cal_state == CAL_IDLE) || (cal_state == CAL_DONE));
  assign latch_ok = i_cal_latch && (cal_state == CAL_STARTED);
  assign mem_waddr = mem_slot(i_cmd.addr);
  assign mem_raddr = mem_slot(i_cmd.addr);
  // Only the strobe timer and the two calibration pattern words live in the memory; test addresses never reach it.
  assign mem_we = i_cmd.wr && !is_test_addr(i_cmd.addr) && (mem_waddr != 2'h3);

  dmrm_regmem #(
    .DEPTH(4)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(i_cmd.data),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Calibration sequencing; a reset drops the result back to invalid.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cal_state <= CAL_IDLE;
      latch_cnt <= 8'h00;
      selftest <= DMRM_SELFTEST_INVALID;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (i_cal_start && !fault) begin
            cal_state <= CAL_STARTED;
          end
        end
        CAL_STARTED: begin
          if (i_cal_latch) begin
            cal_state <= CAL_LATCHING;
            latch_cnt <= 8'(LATCH_CYCLES);
          end
        end
        CAL_LATCHING: begin
          if (latch_cnt <= 8'h01) begin
            cal_state <= CAL_DONE;
            selftest <= i_pin_sense;
          end else begin
            latch_cnt <= latch_cnt - 8'h01;
          end
        end
        CAL_DONE: begin
          if (i_cal_start && !fault) begin
            cal_state <= CAL_STARTED;
          end
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  // A suspected assembly fault locks the drivers to trim values.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_use_factory_trim <= 1'b0;
      o_cal_accepted <= 1'b0;
    end else begin
      o_use_factory_trim <= fault;
      o_cal_accepted <= start_ok || latch_ok;
    end
  end

  // Writable registers; read-only and test numbers fall through untouched.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_strobe_timer_runtime <= DMRM_ZERO_RESET;
      o_row_hammer_control <= DMRM_ZERO_RESET;
      o_single_ended_select <= DMRM_ZERO_RESET;
    end else if (i_cmd.wr) begin
      case (i_cmd.addr)
        DMRM_STROBE_TIMER_RUNTIME: o_strobe_timer_runtime <= i_cmd.data;
        DMRM_ROW_HAMMER_CONTROL: o_row_hammer_control <= i_cmd.data;
        DMRM_SINGLE_ENDED_SELECT: begin
          o_single_ended_select <= i_cmd.data & DMRM_SINGLE_ENDED_MASK;
        end
        default: o_row_hammer_control <= o_row_hammer_control;
      endcase
    end
  end

  // Read stage one: decode and capture immediate data.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pend_rd <= 1'b0;
      pend_strobe <= 1'b0;
      pend_from_mem <= 1'b0;
      pend_data <= DMRM_ZERO_RESET;
    end else begin
      pend_rd <= i_cmd.rd && !is_test_addr(i_cmd.addr);
      pend_strobe <= i_cmd.rd && !is_test_addr(i_cmd.addr);
      pend_from_mem <= 1'b0;
      pend_data <= DMRM_ZERO_RESET;
      if (i_cmd.rd) begin
        case (i_cmd.addr)
          DMRM_DEVICE_STATUS_INFO: begin
            pend_data <= DMRM_ZERO_RESET;
            pend_data[DMRM_REFRESH_MODE_BIT] <= i_refresh_modified_only;
            pend_data[DMRM_SELFTEST_LSB +: 2] <= selftest;
            pend_data[DMRM_CA_TERM_BIT] <= i_ca_term_state;
          end
          DMRM_ROW_HAMMER_CONTROL: pend_data <= o_row_hammer_control;
          DMRM_PER_BANK_STATUS: pend_data <= 8'(i_bank_status);
          DMRM_SINGLE_ENDED_SELECT: pend_data <= o_single_ended_select;
          DMRM_STROBE_TIMER_RUNTIME, DMRM_CALIB_PATTERN_FIRST,
          DMRM_CALIB_PATTERN_SECOND: pend_from_mem <= 1'b1;
          default: pend_data <= DMRM_ZERO_RESET;
        endcase
      end
    end
  end

  // Read stage two: registered answer.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= pend_rd;
      o_rsp.strobe <= pend_strobe;
      o_rsp.data <= pend_from_mem ? mem_rdata : pend_data;
    end
  end
endmodule : dmrm_mode_regs
`default_nettype wire

// ==== test/dmrm_mode_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmrm_mode_regs_asserts
  import dmrm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire dmrm_pkg::dmrm_cmd_s i_cmd,
  input wire dmrm_pkg::dmrm_rsp_s o_rsp,
  input wire logic i_cal_start,
  input wire logic o_use_factory_trim,
  input wire logic o_cal_accepted,
  input wire logic [7:0] o_strobe_timer_runtime,
  input wire logic [7:0] o_row_hammer_control,
  input wire logic [7:0] o_single_ended_select
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence answer_s;
    o_rsp.valid && o_rsp.strobe;
  endsequence
  sequence test_rd_s;
    i_cmd.rd && i_cmd.addr inside {6'h1e, 6'h27};
  endsequence
  read_answer_a: assert property (i_cmd.rd && !(i_cmd.addr inside {6'h1e, 6'h27}) |-> ##2 answer_s)
    else $error("Read got no answer.");
  test_ignore_a: assert property (test_rd_s |-> ##2 !o_rsp.valid)
    else $error("Test register answered.");
  strobe_pair_a: assert property (o_rsp.valid == o_rsp.strobe)
    else $error("Strobe and valid differ.");
  status_zero_a: assert property (i_cmd.rd && i_cmd.addr == 6'h00 |-> ##2
    o_rsp.data[6:5] == 2'h0 && o_rsp.data[2:1] == 2'h0) else $error("Reserved bit set.");
  se_mask_a: assert property ((o_single_ended_select & 8'hf1) == 8'h00)
    else $error("Single ended reserved bit set.");
  trim_refuse_a: assert property (o_use_factory_trim && i_cal_start |=> !o_cal_accepted)
    else $error("Start taken during fault.");
  ro_stable_a: assert property (i_cmd.wr && i_cmd.addr inside {6'h00, 6'h19} |=>
    $stable({o_strobe_timer_runtime, o_row_hammer_control})) else $error("Read-only write acted.");
  timer_write_a: assert property (i_cmd.wr && i_cmd.addr == 6'h17 |=>
    o_strobe_timer_runtime == $past(i_cmd.data)) else $error("Timer write lost.");
endmodule : dmrm_mode_regs_asserts
bind dmrm_mode_regs dmrm_mode_regs_asserts dmrm_mode_regs_asserts_inst (.i_ref_clk, .i_rst_b,
  .i_cmd, .o_rsp, .i_cal_start, .o_use_factory_trim, .o_cal_accepted,
  .o_strobe_timer_runtime, .o_row_hammer_control, .o_single_ended_select);
`default_nettype wire

// ==== test/dmrm_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmrm_ctrl_model
  import dmrm_pkg::*;
(
  // Clock.
  input wire logic i_ref_clk,
  // Commands to the device.
  output dmrm_pkg::dmrm_cmd_s o_cmd
);
  initial o_cmd = '0;
  // Each call owns one edge, so back-to-back commands never assign twice in a step.
  task automatic send(input logic rd, input logic wr, input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == 6'h33) ? (d & 8'h0e) : d;
    @(posedge i_ref_clk);
    if (wr && a inside {[6'h1a:6'h1d], 6'h1f, [6'h21:6'h26], [6'h29:6'h32], [6'h34:6'h3f]}) begin
      o_cmd <= '0;
    end else begin
      o_cmd <= '{rd: rd, wr: wr, addr: a, data: v};
    end
  endtask : send
endmodule : dmrm_ctrl_model
`default_nettype wire

// ==== test/dmrm_mode_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmrm_mode_regs_tb;
  import dmrm_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cal_start = 1'b0;
  logic cal_latch = 1'b0;
  logic [1:0] pin = 2'h0;
  logic [1:0] st = 2'h0;
  logic ref_mod = 1'b0;
  logic ca_term = 1'b0;
  logic [7:0] banks = 8'h00;
  logic [7:0] timer, rh, se, acc_n;
  logic trim, acc;
  dmrm_cmd_s cmd;
  dmrm_rsp_s rsp;
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] mem [64];
  logic [5:0] regs [5] = '{6'h17, 6'h18, 6'h20, 6'h28, 6'h33};
  logic [5:0] odd [7] = '{6'h1a, 6'h1e, 6'h1f, 6'h22, 6'h27, 6'h34, 6'h3f};
  always #50 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk) acc_n <= acc_n + 8'(acc);
  dmrm_ctrl_model dmrm_ctrl_model_inst (.i_ref_clk(i_ref_clk), .o_cmd(cmd));
  dmrm_mode_regs #(.LATCH_CYCLES(1), .BANKS(8)) dmrm_mode_regs_inst (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cmd(cmd), .o_rsp(rsp), .i_cal_start(cal_start),
    .i_cal_latch(cal_latch), .i_pin_sense(pin), .i_refresh_modified_only(ref_mod),
    .i_ca_term_state(ca_term), .i_bank_status(banks), .o_strobe_timer_runtime(timer),
    .o_row_hammer_control(rh), .o_single_ended_select(se), .o_use_factory_trim(trim),
    .o_cal_accepted(acc));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic rd_chk(input logic [5:0] a);
    logic [7:0] d, n, s, w;
    n = 8'h00;
    s = 8'h00;
    d = 8'h00;
    dmrm_ctrl_model_inst.send(1'b1, 1'b0, a, 8'h00);
    dmrm_ctrl_model_inst.send(1'b0, 1'b0, 6'h00, 8'h00);
    // Taken after the sends, so inputs set at the caller's edge have settled.
    w = (a == 6'h00) ? {ca_term, 2'h0, st, 2'h0, ref_mod} : (a == 6'h19) ? banks : mem[a];
    repeat (4) begin
      @(negedge i_ref_clk);
      if (rsp.valid === 1'b1) begin
        n++;
        d = rsp.data;
      end
      if (rsp.strobe === 1'b1) s++;
    end
    check(n, (a inside {6'h1e, 6'h27}) ? 8'h00 : 8'h01);
    check(s, (a inside {6'h1e, 6'h27}) ? 8'h00 : 8'h01);
    check(d, (n == 8'h01) ? w : 8'h00);
  endtask : rd_chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    dmrm_ctrl_model_inst.send(1'b0, 1'b1, a, d);
    if (a inside {6'h17, 6'h18, 6'h20, 6'h28, 6'h33}) mem[a] = (a == 6'h33) ? d & 8'h0e : d;
  endtask : wr
  task automatic cal(input logic [1:0] p);
    logic f;
    f = trim;
    @(posedge i_ref_clk);
    acc_n <= 8'h00;
    pin <= p;
    cal_start <= 1'b1;
    @(posedge i_ref_clk);
    cal_start <= 1'b0;
    cal_latch <= 1'b1;
    @(posedge i_ref_clk);
    cal_latch <= 1'b0;
    repeat (4) @(negedge i_ref_clk);
    if (!f) st = p;
    check(acc_n, f ? 8'h00 : 8'h02);
    check(trim, st inside {2'h1, 2'h2});
    rd_chk(6'h00);
  endtask : cal
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    void'($urandom(32'hde97_fdc3));
    foreach (mem[i]) mem[i] = 8'h00;
    mem[32] = 8'h5a;
    mem[40] = 8'h3c;
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    foreach (regs[i]) rd_chk(regs[i]);
    $display("Test defaults done");
    foreach (regs[i]) wr(regs[i], 8'($urandom));
    wr(6'h00, 8'hff);
    wr(6'h19, 8'hff);
    wr(6'h1e, 8'hff);
    dmrm_ctrl_model_inst.send(1'b0, 1'b0, 6'h00, 8'h00);
    repeat (2) @(negedge i_ref_clk);
    check(timer, mem[23]);
    check(rh, mem[24]);
    check(se, mem[51]);
    foreach (regs[i]) rd_chk(regs[i]);
    foreach (odd[i]) rd_chk(odd[i]);
    $display("Test writes done");
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      ref_mod <= k[0];
      ca_term <= ~k[0];
      banks <= 8'($urandom);
      rd_chk(6'h00);
      rd_chk(6'h19);
    end
    cal(2'h3);
    cal(2'h1);
    cal(2'h3);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    st = 2'h0;
    rd_chk(6'h00);
    check(trim, 1'b0);
    $display("Test calibration done");
    results();
  end
endmodule : dmrm_mode_regs_tb
`default_nettype wire
